// ===== hw/psf_defs.svh
// Bit positions, register offsets and timing counts for the processor status flags block
`ifndef PSF_DEFS_SVH
`define PSF_DEFS_SVH
`define PSF_BIT_CARRY 0
`define PSF_BIT_STEP 1
`define PSF_BIT_ZERO 2
`define PSF_BIT_SIGN 3
`define PSF_BIT_BANK 4
`define PSF_BIT_OVFL 5
`define PSF_BIT_IEN 6
`define PSF_BIT_USTK 7
`define PSF_IPL_LO 12
`define PSF_IPL_HI 14
`define PSF_WRITE_MASK 16'h70ff
`define PSF_RESET_VAL 16'h0000
`define PSF_OFS_STATUS 8'h00
`define PSF_OFS_CTRL 8'h04
`define PSF_OFS_EVENT 8'h08
`define PSF_CTRL_SWRST 0
`define PSF_CTRL_STEP_REQ 1
`define PSF_EVT_STEP 0
`define PSF_EVT_ACCEPT 1
`define PSF_EVT_FETCH 2
`define PSF_TRAP_LAST 8'h1f
`define PSF_RESET_MIN_CYC 20
`endif

// ===== hw/psf_pkg.sv
// Types shared by the processor status flags block
package psf_pkg;
   typedef struct packed {
      logic valid;
      logic [15:0] result;
      logic carry;
      logic ovfl;
   } psf_alu_s;
   typedef struct packed {
      logic valid;
      logic [2:0] prio;
      logic hw;
   } psf_irq_s;
   typedef enum logic [1:0] {ST_HOLD, ST_FETCH, ST_RUN} psf_boot_e;
endpackage

// ===== hw/psf_flag_eval.sv
// Condition flag evaluation from an arithmetic result
`timescale 1ns/1ps
module psf_flag_eval
(
   input wire psf_pkg::psf_alu_s i_alu,
   output logic o_zero,
   output logic o_sign
);
   always_comb
   begin
      o_zero = (i_alu.result == 16'h0000);
      o_sign = i_alu.result[15];
   end
endmodule

// ===== hw/psf_irq_gate.sv
// Interrupt acceptance gate against enable and priority level
`timescale 1ns/1ps
module psf_irq_gate
(
   input wire psf_pkg::psf_irq_s i_req,
   input wire logic i_ien,
   input wire logic [2:0] i_level,
   output logic o_accept
);
   // Hardware requests obey the enable bit and strict priority comparison
   always_comb
   begin
      o_accept = i_req.valid && i_req.hw && i_ien && (i_req.prio > i_level);
   end
endmodule

// ===== hw/psf_status_top.sv
// Processor status word with Wishbone register access and reset sequencing
// Overview of operation
// - Bit 0 keeps carry, borrow or shifted-out bit of latest operation.
// - Bit 1 raises single-step request per instruction; cleared on acknowledge.
// - Bit 2 is one for a zero result, zero otherwise.
// - Bit 3 is one for a negative result, zero otherwise.
// - Bit 4 selects register bank 0 or 1.
// - Bit 5 is one on arithmetic overflow, zero otherwise.
// - Bit 6 enables maskable interrupts; cleared on any acknowledge.
// - Bit 7 selects interrupt stack when zero, user stack when one.
// - Bit 7 cleared on hardware acknowledge or trap numbers 0 to 31.
// - Bits 12 to 14 hold current priority level 0 to 7.
// - Requests accepted only if priority strictly exceeds current level.
// - Bits 8 to 11 and 15 are reserved without function.
// - After reset release, fetch reset vector then start execution.
// - Hardware and software reset give identical status word and boot sequence; software reset keeps event bits.
`timescale 1ns/1ps
`include "psf_defs.svh"
module psf_status_top
(
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   input wire logic [7:0] I_WB_ADR,
   input wire logic [31:0] I_WB_DAT,
   input wire logic I_WB_WE,
   input wire logic [3:0] I_WB_SEL,
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   output logic [31:0] O_WB_DAT,
   output logic O_WB_ACK,
   input wire psf_pkg::psf_alu_s I_ALU,
   input wire logic I_INSN_DONE,
   input wire logic I_STEP_ACK,
   input wire psf_pkg::psf_irq_s I_IRQ,
   input wire logic I_TRAP,
   input wire logic [7:0] I_TRAP_NUM,
   input wire logic I_FETCH_DONE,
   output logic [15:0] O_STATUS,
   output logic O_BANK_SEL,
   output logic O_USER_STACK,
   output logic O_IRQ_ACCEPT,
   output logic O_STEP_IRQ,
   output logic O_VEC_FETCH,
   output logic O_RUN
);
   logic [15:0] psw_ff;
   logic [15:0] nxt_psw;
   logic ack_ff;
   logic [31:0] rdat_ff;
   logic step_ff;
   logic [2:0] evt_ff;
   logic swrst_ff;
   psf_pkg::psf_boot_e boot_ff;
   logic zero_w;
   logic sign_w;
   logic accept_w;
   logic req_w;
   logic wr_w;
   logic rd_clr_w;
   logic trap_low_w;

   psf_flag_eval u_eval
   (
      .i_alu(I_ALU),
      .o_zero(zero_w),
      .o_sign(sign_w)
   );

   psf_irq_gate u_gate
   (
      .i_req(I_IRQ),
      .i_ien(psw_ff[`PSF_BIT_IEN]),
      .i_level(psw_ff[`PSF_IPL_HI:`PSF_IPL_LO]),
      .o_accept(accept_w)
   );

   assign req_w = I_WB_CYC && I_WB_STB && !ack_ff;
   assign wr_w = req_w && I_WB_WE;
   assign trap_low_w = I_TRAP && (I_TRAP_NUM <= `PSF_TRAP_LAST);

   // Status word next value; software write wins only where hardware is idle
   always_comb
   begin
      nxt_psw = psw_ff;
      if (wr_w && (I_WB_ADR == `PSF_OFS_STATUS))
      begin
         if (I_WB_SEL[0])
            nxt_psw[7:0] = I_WB_DAT[7:0];
         if (I_WB_SEL[1])
            nxt_psw[15:8] = I_WB_DAT[15:8];
      end
      if (I_ALU.valid)
      begin
         nxt_psw[`PSF_BIT_CARRY] = I_ALU.carry;
         nxt_psw[`PSF_BIT_ZERO] = zero_w;
         nxt_psw[`PSF_BIT_SIGN] = sign_w;
         nxt_psw[`PSF_BIT_OVFL] = I_ALU.ovfl;
      end
      if (I_STEP_ACK)
         nxt_psw[`PSF_BIT_STEP] = 1'b0;
      if (accept_w || I_STEP_ACK)
         nxt_psw[`PSF_BIT_IEN] = 1'b0;
      if (accept_w || trap_low_w)
         nxt_psw[`PSF_BIT_USTK] = 1'b0;
      nxt_psw = nxt_psw & `PSF_WRITE_MASK;
   end

   // Software reset loads the same reset value as the pin so both end identically
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         psw_ff <= `PSF_RESET_VAL;
      else if (swrst_ff)
         psw_ff <= `PSF_RESET_VAL;
      else if (boot_ff == psf_pkg::ST_RUN)
         psw_ff <= nxt_psw;
   end

   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         swrst_ff <= 1'b0;
      else
         swrst_ff <= wr_w && (I_WB_ADR == `PSF_OFS_CTRL) && I_WB_SEL[0]
            && I_WB_DAT[`PSF_CTRL_SWRST];
   end

   // The pin length is the source's duty; the core just waits for release
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         boot_ff <= psf_pkg::ST_HOLD;
      else if (swrst_ff)
         boot_ff <= psf_pkg::ST_HOLD;
      else
      begin
         case (boot_ff)
            psf_pkg::ST_HOLD: boot_ff <= psf_pkg::ST_FETCH;
            psf_pkg::ST_FETCH:
               if (I_FETCH_DONE)
                  boot_ff <= psf_pkg::ST_RUN;
            default: boot_ff <= psf_pkg::ST_RUN;
         endcase
      end
   end

   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         step_ff <= 1'b0;
      else if (swrst_ff)
         step_ff <= 1'b0;
      else
         step_ff <= I_INSN_DONE && psw_ff[`PSF_BIT_STEP] && (boot_ff == psf_pkg::ST_RUN);
   end

   assign rd_clr_w = req_w && !I_WB_WE && (I_WB_ADR == `PSF_OFS_EVENT);

   // Sticky event bits: a new event in the clearing read's cycle survives
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         evt_ff <= 3'h0;
      else
      begin
         evt_ff <= (rd_clr_w ? 3'h0 : evt_ff)
            | {I_FETCH_DONE && (boot_ff == psf_pkg::ST_FETCH), accept_w, step_ff};
      end
   end

   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         ack_ff <= 1'b0;
      else
         ack_ff <= req_w;
   end

   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         rdat_ff <= 32'h0000_0000;
      else if (req_w && !I_WB_WE)
      begin
         if (I_WB_ADR == `PSF_OFS_STATUS)
            rdat_ff <= {16'h0000, psw_ff & `PSF_WRITE_MASK};
         else if (I_WB_ADR == `PSF_OFS_CTRL)
            rdat_ff <= {30'h0, boot_ff == psf_pkg::ST_RUN, 1'b0};
         else if (I_WB_ADR == `PSF_OFS_EVENT)
            rdat_ff <= {29'h0, evt_ff};
         else
            rdat_ff <= 32'h0000_0000;
      end
   end

   assign O_WB_ACK = ack_ff;
   assign O_WB_DAT = rdat_ff;
   assign O_STATUS = psw_ff;
   assign O_BANK_SEL = psw_ff[`PSF_BIT_BANK];
   assign O_USER_STACK = psw_ff[`PSF_BIT_USTK];
   assign O_IRQ_ACCEPT = accept_w && (boot_ff == psf_pkg::ST_RUN);
   assign O_STEP_IRQ = step_ff;
   assign O_VEC_FETCH = (boot_ff == psf_pkg::ST_FETCH);
   assign O_RUN = (boot_ff == psf_pkg::ST_RUN);

   // Checks
   property p_carry;
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (I_ALU.valid && O_RUN && !swrst_ff) |=> (psw_ff[0] == $past(I_ALU.carry));
   endproperty
   a_carry: assert property (p_carry) else $error("carry not captured");
   property p_zero;
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (I_ALU.valid && O_RUN && !swrst_ff) |=> (psw_ff[2] == ($past(I_ALU.result) == 16'h0000));
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   property p_sign;
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (I_ALU.valid && O_RUN && !swrst_ff) |=> (psw_ff[3] == $past(I_ALU.result[15]));
   endproperty
   a_sign: assert property (p_sign) else $error("sign flag wrong");
   property p_ovfl;
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (I_ALU.valid && O_RUN && !swrst_ff) |=> (psw_ff[5] == $past(I_ALU.ovfl));
   endproperty
   a_ovfl: assert property (p_ovfl) else $error("overflow flag wrong");
   property p_accept;
      @(posedge I_CLK) disable iff (!I_RESET_N)
      O_IRQ_ACCEPT |-> (psw_ff[6] && (I_IRQ.prio > psw_ff[14:12]));
   endproperty
   a_accept: assert property (p_accept) else $error("accept without enable or level");
   property p_ien_clr;
      @(posedge I_CLK) disable iff (!I_RESET_N)
      O_IRQ_ACCEPT |=> !psw_ff[6] && !psw_ff[7];
   endproperty
   a_ien_clr: assert property (p_ien_clr) else $error("enable or stack bit kept");
   property p_trap;
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (I_TRAP && I_TRAP_NUM <= 8'h1f && O_RUN) |=> !psw_ff[7];
   endproperty
   a_trap: assert property (p_trap) else $error("trap left user stack");
   property p_step;
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (I_INSN_DONE && psw_ff[1] && O_RUN && !swrst_ff) |=> O_STEP_IRQ;
   endproperty
   a_step: assert property (p_step) else $error("step request missing");
   property p_resv;
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (psw_ff[11:8] == 4'h0) && !psw_ff[15];
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bit set");
   property p_resv_rd;
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (req_w && !I_WB_WE && (I_WB_ADR == 8'h00)) |=> ((O_WB_DAT[31:16] == 16'h0000)
         && (O_WB_DAT[11:8] == 4'h0) && !O_WB_DAT[15]);
   endproperty
   a_resv_rd: assert property (p_resv_rd) else $error("reserved bit read nonzero");
   property p_step_clr;
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (I_STEP_ACK && O_RUN) |=> (!psw_ff[1] && !psw_ff[6]);
   endproperty
   a_step_clr: assert property (p_step_clr) else $error("step acknowledge kept enables");
   property p_block;
      @(posedge I_CLK) disable iff (!I_RESET_N)
      !psw_ff[6] |-> !O_IRQ_ACCEPT;
   endproperty
   a_block: assert property (p_block) else $error("request accepted while masked");
   property p_ipl;
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (wr_w && (I_WB_ADR == 8'h00) && I_WB_SEL[1] && O_RUN && !swrst_ff)
         |=> (psw_ff[14:12] == $past(I_WB_DAT[14:12]));
   endproperty
   a_ipl: assert property (p_ipl) else $error("priority level not written");
   // Before the vector fetch ends the word only moves by a reset
   property p_hold;
      @(posedge I_CLK) disable iff (!I_RESET_N)
      !O_RUN |=> ($stable(psw_ff) || (psw_ff == 16'h0000));
   endproperty
   a_hold: assert property (p_hold) else $error("status changed before run");
   property p_fetch;
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (O_VEC_FETCH && I_FETCH_DONE && !swrst_ff) |=> O_RUN;
   endproperty
   a_fetch: assert property (p_fetch) else $error("run missing after fetch");
   property p_run_hold;
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (O_RUN && !swrst_ff) |=> O_RUN;
   endproperty
   a_run_hold: assert property (p_run_hold) else $error("run dropped without reset");
   sequence s_swrst;
      swrst_ff;
   endsequence
   // Hold state first, then fetch, exactly as after the pin is released
   sequence s_clean;
      ((psw_ff == 16'h0000) && !O_VEC_FETCH && !O_RUN)
         ##1 (O_VEC_FETCH && (psw_ff == 16'h0000));
   endsequence
   property p_swrst;
      @(posedge I_CLK) disable iff (!I_RESET_N)
      s_swrst |=> s_clean;
   endproperty
   a_swrst: assert property (p_swrst) else $error("soft reset state differs");
endmodule

// ===== test/psf_core_model.sv
// Core model: answers the reset vector fetch and acknowledges single-step requests
`timescale 1ns/1ps
module psf_core_model
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_vec_fetch,
   input wire logic i_step_irq,
   input wire logic [3:0] i_lat,
   output logic o_fetch_done,
   output logic o_step_ack
);
   logic [3:0] cnt_ff;
   // Latency is set by the bench so that both a prompt and a slow fetch occur
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_ff <= 4'h0;
         o_fetch_done <= 1'b0;
         o_step_ack <= 1'b0;
      end
      else
      begin
         o_fetch_done <= i_vec_fetch && !o_fetch_done && cnt_ff == i_lat;
         cnt_ff <= (i_vec_fetch && !o_fetch_done) ? cnt_ff + 4'h1 : 4'h0;
         o_step_ack <= i_step_irq;
      end
   end
endmodule

// ===== test/tb_processor_status_flags.sv
// Self-checking bench for the processor status word
`timescale 1ns/1ps
`include "psf_defs.svh"
module tb_processor_status_flags;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic [3:0] sel = 4'h0;
   psf_pkg::psf_alu_s alu = '0;
   psf_pkg::psf_irq_s irq = '0;
   logic insn_done = 1'b0;
   logic trap = 1'b0;
   logic [7:0] trap_num = 8'h00;
   logic [3:0] lat = 4'h0;
   logic [31:0] rdat, q;
   logic [15:0] status;
   logic ack, step_ack, fetch_done, bank, ustk, accept, step_irq, vec_fetch, run;
   int error_cnt = 0;
   int n_checks = 0;
   int cycles = 0;

   initial
   begin
      forever #25 clk = ~clk;
   end

   psf_status_top dut_u (.I_CLK(clk), .I_RESET_N(rst_n), .I_WB_ADR(adr), .I_WB_DAT(wdat),
      .I_WB_WE(we), .I_WB_SEL(sel), .I_WB_CYC(cyc), .I_WB_STB(stb), .O_WB_DAT(rdat),
      .O_WB_ACK(ack), .I_ALU(alu), .I_INSN_DONE(insn_done), .I_STEP_ACK(step_ack),
      .I_IRQ(irq), .I_TRAP(trap), .I_TRAP_NUM(trap_num), .I_FETCH_DONE(fetch_done),
      .O_STATUS(status), .O_BANK_SEL(bank), .O_USER_STACK(ustk), .O_IRQ_ACCEPT(accept),
      .O_STEP_IRQ(step_irq), .O_VEC_FETCH(vec_fetch), .O_RUN(run));

   psf_core_model core_u (.i_clk(clk), .i_rst_n(rst_n), .i_vec_fetch(vec_fetch),
      .i_step_irq(step_irq), .i_lat(lat), .o_fetch_done(fetch_done), .o_step_ack(step_ack));

   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Classic cycle: request held until ack is seen at a rising edge
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s = 4'hf);
      int n;
      n = 0;
      @(posedge clk);
      adr <= a;
      we <= w;
      wdat <= d;
      cyc <= 1'b1;
      stb <= 1'b1;
      sel <= s;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      chk({31'h0, ack}, 32'h1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic wait_run();
      int n;
      n = 0;
      while (run !== 1'b1 && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      chk({31'h0, run}, 32'h1);
   endtask

   task automatic alu_op(input logic [15:0] r, input logic c, input logic o,
      input logic [15:0] e);
      @(posedge clk);
      alu <= {1'b1, r, c, o};
      @(posedge clk);
      alu <= '0;
      @(negedge clk);
      chk({16'h0, status}, {16'h0, e});
   endtask

   task automatic trap_op(input logic [7:0] n, input logic [15:0] e);
      @(posedge clk);
      trap <= 1'b1;
      trap_num <= n;
      @(posedge clk);
      trap <= 1'b0;
      @(negedge clk);
      chk({16'h0, status}, {16'h0, e});
   endtask

   task automatic insn();
      @(posedge clk);
      insn_done <= 1'b1;
      @(posedge clk);
      insn_done <= 1'b0;
      @(negedge clk);
   endtask

   task automatic t_reset();
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      settle(1);
      chk({30'h0, vec_fetch, run}, 32'h2);
      wait_run();
      chk({16'h0, status}, 32'h0);
      $display("reset test done");
   endtask

   task automatic t_alu();
      alu_op(16'h0000, 1'b1, 1'b0, 16'h0005);
      alu_op(16'h8000, 1'b0, 1'b1, 16'h0028);
      alu_op(16'h1234, 1'b1, 1'b0, 16'h0001);
      $display("alu test done");
   endtask

   task automatic t_write();
      wb(`PSF_OFS_STATUS, 1'b1, 32'hffff_ffff);
      wb(`PSF_OFS_STATUS, 1'b0, 32'h0);
      chk(q, 32'h0000_70ff);
      chk({30'h0, bank, ustk}, 32'h3);
      wb(`PSF_OFS_STATUS, 1'b1, 32'h0000_0080);
      chk({30'h0, bank, ustk}, 32'h1);
      wb(`PSF_OFS_STATUS, 1'b1, 32'h0000_70ff, 4'h2);
      wb(`PSF_OFS_STATUS, 1'b0, 32'h0);
      chk(q, 32'h0000_7080);
      wb(8'h0c, 1'b1, 32'hffff_ffff);
      wb(8'h0c, 1'b0, 32'h0);
      chk(q, 32'h0);
      $display("write test done");
   endtask

   task automatic t_irq();
      wb(`PSF_OFS_STATUS, 1'b1, 32'h0000_30c0);
      irq <= {1'b1, 3'd3, 1'b1};
      @(negedge clk);
      chk({31'h0, accept}, 32'h0);
      @(posedge clk);
      irq <= {1'b1, 3'd4, 1'b1};
      @(negedge clk);
      chk({31'h0, accept}, 32'h1);
      @(posedge clk);
      irq <= '0;
      @(negedge clk);
      chk({16'h0, status}, 32'h0000_3000);
      @(posedge clk);
      irq <= {1'b1, 3'd7, 1'b1};
      @(negedge clk);
      chk({31'h0, accept}, 32'h0);
      @(posedge clk);
      irq <= '0;
      wb(`PSF_OFS_EVENT, 1'b0, 32'h0);
      chk(q, 32'h0000_0006);
      wb(`PSF_OFS_EVENT, 1'b0, 32'h0);
      chk(q, 32'h0);
      $display("irq test done");
   endtask

   task automatic t_trap();
      wb(`PSF_OFS_STATUS, 1'b1, 32'h0000_0080);
      trap_op(8'h20, 16'h0080);
      trap_op(8'h1f, 16'h0000);
      $display("trap test done");
   endtask

   task automatic t_step();
      wb(`PSF_OFS_STATUS, 1'b1, 32'h0000_0042);
      insn();
      chk({31'h0, step_irq}, 32'h1);
      settle(3);
      chk({16'h0, status}, 32'h0);
      insn();
      chk({31'h0, step_irq}, 32'h0);
      wb(`PSF_OFS_EVENT, 1'b0, 32'h0);
      chk(q, 32'h0000_0001);
      $display("step test done");
   endtask

   // Slow core on purpose, so the fetch state is held for several cycles
   task automatic t_swrst();
      lat <= 4'h6;
      wb(`PSF_OFS_STATUS, 1'b1, 32'h0000_70ff);
      wb(`PSF_OFS_CTRL, 1'b1, 32'h1);
      settle(2);
      chk({14'h0, status, vec_fetch, run}, 32'h2);
      wait_run();
      wb(`PSF_OFS_CTRL, 1'b0, 32'h0);
      chk(q, 32'h2);
      $display("soft reset test done");
   endtask

   initial
   begin
      t_reset();
      t_alu();
      t_write();
      t_irq();
      t_trap();
      t_step();
      t_swrst();
      wrap_up();
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         error_cnt++;
         wrap_up();
      end
   end
endmodule
